// ==== hdl/fpe_regs.svh ====
// Opcodes, status bit positions and size constants of the program/erase sequencer.
`ifndef FPE_REGS_SVH
`define FPE_REGS_SVH
// ----------------------------------------
// Command opcodes
// ----------------------------------------
`define FPE_OPC_WRITE_ENABLE_CMD      8'h06
`define FPE_OPC_WRDIS     8'h04
`define FPE_OPC_CLRSR     8'h30
`define FPE_OPC_PROG      8'h02
`define FPE_OPC_PROG_W    8'h12
`define FPE_OPC_PERASE    8'h20
`define FPE_OPC_PERASE_W  8'h21
`define FPE_OPC_SERASE    8'hd8
`define FPE_OPC_SERASE_W  8'hdc
`define FPE_OPC_BULK_A    8'h60
`define FPE_OPC_BULK_B    8'hc7
// ----------------------------------------
// Status register one bit positions
// ----------------------------------------
`define FPE_SR1_WIP       0
`define FPE_SR1_WEL       1
`define FPE_SR1_EERR      5
`define FPE_SR1_PERR      6
// ----------------------------------------
// Sizes and counts
// ----------------------------------------
`define FPE_PAGE_MASK_256 9'h0ff
`define FPE_PAGE_MASK_512 9'h1ff
`define FPE_PSECT_LAST    18'h00fff
`define FPE_SECT_LAST     18'h3ffff
`define FPE_PARAM_LSB     15
`define FPE_ERASED_BYTE   8'hff
`define FPE_CNT_SAT       3'd6
`endif

// ==== hdl/fpe_pkg.sv ====
// Types shared by the program/erase sequencer modules.
package fpe_pkg;
  // Sequencer states.
  typedef enum logic [2:0] {
    ST_IDLE, ST_FRAME, ST_CHECK, ST_PRD, ST_PWAIT, ST_PWR, ST_ERASE, ST_DONE
  } fpe_state_t;
  // Decoded command classes.
  typedef enum logic [2:0] {
    OP_NONE, OP_WEN, OP_WDI, OP_CLR, OP_PROG, OP_PERASE, OP_SERASE
  } fpe_op_t;
endpackage : fpe_pkg

// ==== hdl/fpe_link_rx.sv ====
// Serial/quad byte receiver running on the link clock.
`timescale 1ns/1ps
module fpe_link_rx
  import fpe_pkg::*;
(
  input  wire logic       sck_i,        // Link clock from the host.
  input  wire logic       cs_n_i,       // Chip select, low in a frame.
  input  wire logic [3:0] io_i,         // IO lines; io_i[0] is serial in.
  input  wire logic       quad_mode_i,  // Quad-all mode, quasi-static.
  input  wire logic       reset_i,      // System reset.
  output logic      [7:0] byte_o,       // Last complete byte.
  output logic            byte_tgl_o    // Flips once per complete byte.
);
  logic [7:0] shift_reg,  shift_next;   // Bits of the byte in flight.
  logic [3:0] bits_reg,   bits_next;    // Bits gathered so far.
  logic [7:0] byte_next;
  logic       tgl_next;

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  // Quad mode takes a nibble per edge, high nibble first, so one byte
  // costs two clocks; serial mode takes one bit per edge.
  // The mode bit is read directly. It only changes between frames, while the
  // link clock stands still, and a stage clocked here would need link edges to
  // settle, so the first edges of a frame would use the old mode.
  always_comb begin
    shift_next = quad_mode_i ? {shift_reg[3:0], io_i} : {shift_reg[6:0], io_i[0]};
    bits_next  = bits_reg + (quad_mode_i ? 4'd4 : 4'd1);
    byte_next  = byte_o;
    tgl_next   = byte_tgl_o;
    if (bits_next[3]) begin
      bits_next = 4'd0;
      byte_next = shift_next;
      tgl_next  = ~byte_tgl_o;
    end
  end

  // ----------------------------------------
  // Frame registers
  // ----------------------------------------
  // Chip select high clears the bit count at once, since the link clock
  // may stand still between frames.
  always_ff @(posedge sck_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      shift_reg <= 8'h00;
      bits_reg  <= 4'h0;
    end else begin
      shift_reg <= shift_next;
      bits_reg  <= bits_next;
    end
  end

  // The byte and its toggle outlive the frame so the system side can read them.
  always_ff @(posedge sck_i or posedge reset_i) begin
    if (reset_i) begin
      byte_o        <= 8'h00;
      byte_tgl_o    <= 1'b0;
    end else begin
      byte_o        <= byte_next;
      byte_tgl_o    <= tgl_next;
    end
  end
endmodule : fpe_link_rx

// ==== hdl/fpe_page_buffer.sv ====
// Page program buffer of 512 bytes with a per-byte loaded mask.
`timescale 1ns/1ps
module fpe_page_buffer
  import fpe_pkg::*;
(
  input  wire logic       clk_i,      // System clock.
  input  wire logic       reset_i,    // Synchronous reset.
  input  wire logic       clr_i,      // Forget all loaded bytes.
  input  wire logic       wr_i,       // Load one byte.
  input  wire logic [8:0] wr_idx_i,   // Load position in the page.
  input  wire logic [7:0] wr_data_i,  // Byte to load.
  input  wire logic [8:0] rd_idx_i,   // Read position in the page.
  output logic      [7:0] rd_data_o,  // Byte at the read position.
  output logic            rd_valid_o  // The byte was loaded this frame.
);
  logic [7:0]   mem [512];            // Buffer storage, no reset needed.
  logic [511:0] mask_reg, mask_next;  // One loaded flag per byte.

  // ----------------------------------------
  // Loaded mask
  // ----------------------------------------
  // A reload of the same byte just overwrites it, which gives the wrap.
  always_comb begin
    mask_next = clr_i ? 512'h0 : mask_reg;
    if (wr_i) begin
      mask_next[wr_idx_i] = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      mask_reg <= 512'h0;
    end else begin
      mask_reg <= mask_next;
    end
    if (wr_i) begin
      mem[wr_idx_i] <= wr_data_i;
    end
  end

  assign rd_data_o  = mem[rd_idx_i];
  assign rd_valid_o = mask_reg[rd_idx_i];
endmodule : fpe_page_buffer

// ==== hdl/fpe_sequencer.sv ====
// Program and erase command sequencer of the serial flash.
//
// Overview of operation
// - Program needs the write enable latch set.
// - Programming only clears bits, never sets.
// - 02h address length per bit; 12h four.
// - Page buffer is 256 or 512 bytes.
// - Load pointer wraps inside the page.
// - Short loads leave other page bytes alone.
// - Write in progress shows ongoing programming.
// - Protected programming sets program error.
// - Quad-all mode takes two clocks per byte.
// - Uniform layout ignores parameter erase opcodes.
// - Parameter erase writes 4 KB of FFh.
// - 20h address length per bit; 21h four.
// - Erase runs only if select rises after address.
// - Erase starts at select rise, sets progress.
// - Protected parameter erase sets erase error.
// - Parameter erase outside 32 KB area: ignored.
// - D8h address length per bit; DCh four.
// - Sector erase fills sector, needs latch.
// - Protected sector erase sets erase error.
// - Sector erase skips overlaid parameter sectors.
// - Uniform layout erases whole 256 KB sector.
// - Bulk erase opcodes are not supported.
`timescale 1ns/1ps
`include "fpe_regs.svh"
module fpe_sequencer
  import fpe_pkg::*;
(
  input  wire logic        clk_i,                // System clock, 100 MHz.
  input  wire logic        reset_i,              // Synchronous, active high.
  input  wire logic        sck_i,                // Link clock from the host.
  input  wire logic        cs_n_i,               // Chip select pin.
  input  wire logic [3:0]  io_i,                 // IO pins, input side.
  input  wire logic        quad_all_mode_i,      // Quad-all mode enable.
  input  wire logic        address_length_bit_i, // 1: four address bytes.
  input  wire logic        page_size_bit_i,      // 1: 512-byte page.
  input  wire logic        sector_layout_bit_i,  // 1: uniform sectors only.
  input  wire logic        param_top_i,          // 1: parameter sectors on top.
  input  wire logic        protect_hit_i,        // Queried sector is protected.
  input  wire logic [7:0]  arr_rdata_i,          // Array data, one cycle after read.
  output logic      [26:0] prot_addr_o,          // Address under protection query.
  output logic      [26:0] arr_addr_o,           // Array byte address.
  output logic             arr_rd_o,             // Array read strobe.
  output logic             arr_wr_o,             // Array write strobe.
  output logic      [7:0]  arr_wdata_o,          // Array write data.
  output logic      [7:0]  status_reg_one_o      // Status register one image.
);
  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  // Classify an opcode; bulk erase opcodes fall to OP_NONE.
  function automatic fpe_op_t decode_op(input logic [7:0] opc);
    fpe_op_t op;
    op = OP_NONE;
    if (opc == `FPE_OPC_WRITE_ENABLE_CMD) begin
      op = OP_WEN;
    end else if (opc == `FPE_OPC_WRDIS) begin
      op = OP_WDI;
    end else if (opc == `FPE_OPC_CLRSR) begin
      op = OP_CLR;
    end else if (opc == `FPE_OPC_PROG || opc == `FPE_OPC_PROG_W) begin
      op = OP_PROG;
    end else if (opc == `FPE_OPC_PERASE || opc == `FPE_OPC_PERASE_W) begin
      op = OP_PERASE;
    end else if (opc == `FPE_OPC_SERASE || opc == `FPE_OPC_SERASE_W) begin
      op = OP_SERASE;
    end
    return op;
  endfunction : decode_op

  // Opcodes that always carry a four-byte address.
  function automatic logic wide_op(input logic [7:0] opc);
    return opc == `FPE_OPC_PROG_W || opc == `FPE_OPC_PERASE_W ||
           opc == `FPE_OPC_SERASE_W;
  endfunction : wide_op

  // True when the address falls in the 32 KB parameter overlay.
  function automatic logic in_param(input logic [26:0] a, input logic top);
    logic [11:0] hi;
    hi = a[26:`FPE_PARAM_LSB];
    return top ? (hi == 12'hfff) : (hi == 12'h000);
  endfunction : in_param

  // ----------------------------------------
  // Link receiver and crossing
  // ----------------------------------------
  logic [7:0] link_byte;   // Held stable for a whole byte time.
  logic       link_tgl;    // Flips once per received byte.

  fpe_link_rx u_link (
    .sck_i       (sck_i),
    .cs_n_i      (cs_n_i),
    .io_i        (io_i),
    .quad_mode_i (quad_all_mode_i),
    .reset_i     (reset_i),
    .byte_o      (link_byte),
    .byte_tgl_o  (link_tgl)
  );

  logic tgl_meta_reg;   // Toggle synchroniser, stage one.
  logic tgl_sync_reg;   // Toggle synchroniser, stage two.
  logic tgl_dly_reg;    // Previous synchronised toggle.
  logic cs_meta_reg;    // Select synchroniser, stage one.
  logic cs_sync_reg;    // Select synchroniser, stage two.
  logic cs_dly_reg;     // One extra stage for select.
  logic cs_dly2_reg;    // Previous delayed select.
  logic byte_stb;       // A new byte is ready.
  logic cs_fall;        // Frame begins.
  logic cs_rise;        // Frame ends.

  // The byte register is only read after the toggle has crossed, and it
  // stays put for at least two link edges, eight in serial mode, so it needs no synchroniser.
  // Select runs one stage behind the toggle so the last byte of a frame
  // is always taken before its end is seen.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      tgl_meta_reg <= 1'b0;
      tgl_sync_reg <= 1'b0;
      tgl_dly_reg  <= 1'b0;
      cs_meta_reg  <= 1'b1;
      cs_sync_reg  <= 1'b1;
      cs_dly_reg   <= 1'b1;
      cs_dly2_reg  <= 1'b1;
    end else begin
      tgl_meta_reg <= link_tgl;
      tgl_sync_reg <= tgl_meta_reg;
      tgl_dly_reg  <= tgl_sync_reg;
      cs_meta_reg  <= cs_n_i;
      cs_sync_reg  <= cs_meta_reg;
      cs_dly_reg   <= cs_sync_reg;
      cs_dly2_reg  <= cs_dly_reg;
    end
  end

  assign byte_stb = tgl_sync_reg ^ tgl_dly_reg;
  assign cs_fall  = cs_dly2_reg & ~cs_dly_reg;
  assign cs_rise  = ~cs_dly2_reg & cs_dly_reg;

  // ----------------------------------------
  // Sequencer state
  // ----------------------------------------
  fpe_state_t  state_reg, state_next;   // Sequencer state.
  fpe_op_t     op_reg,    op_next;      // Command of this frame.
  logic        wide_reg,  wide_next;    // Four address bytes expected.
  logic [2:0]  cnt_reg,   cnt_next;     // Bytes in frame, saturating.
  logic [31:0] addr_reg,  addr_next;    // Assembled address.
  logic [8:0]  ptr_reg,   ptr_next;     // Buffer load pointer.
  logic [17:0] idx_reg,   idx_next;     // Program index or erase offset.
  logic        wel_reg,   wel_next;     // Write enable latch.
  logic        perr_reg,  perr_next;    // Program error flag.
  logic        eerr_reg,  eerr_next;    // Erase error flag.
  logic [26:0] arr_addr_next;
  logic        arr_rd_next;
  logic        arr_wr_next;
  logic [7:0]  arr_wdata_next;
  logic [7:0]  status_next;

  // Buffer handshake signals.
  logic        buf_clr;
  logic        buf_wr;
  logic [8:0]  buf_wr_idx;
  logic [7:0]  buf_rdata;
  logic        buf_valid;

  // Derived values.
  logic [8:0]  pmask;       // Page offset mask.
  logic [2:0]  nb;          // Address bytes of this command.
  logic [17:0] limit;       // Last index of the running loop.
  logic        last;        // Loop reaches its last index.
  logic [26:0] a27;         // Address within the array.
  logic [26:0] ebyte;       // Byte under erase.

  fpe_page_buffer u_buf (
    .clk_i      (clk_i),
    .reset_i    (reset_i),
    .clr_i      (buf_clr),
    .wr_i       (buf_wr),
    .wr_idx_i   (buf_wr_idx),
    .wr_data_i  (link_byte),
    .rd_idx_i   (idx_reg[8:0]),
    .rd_data_o  (buf_rdata),
    .rd_valid_o (buf_valid)
  );

  // Page size follows the configuration bit; the page is size-aligned.
  assign pmask = page_size_bit_i ? `FPE_PAGE_MASK_512 : `FPE_PAGE_MASK_256;
  assign nb    = wide_reg ? 3'd4 : 3'd3;
  assign a27   = addr_reg[26:0];
  assign limit = (op_reg == OP_PROG)   ? {9'h000, pmask} :
                 (op_reg == OP_PERASE) ? `FPE_PSECT_LAST : `FPE_SECT_LAST;
  assign last  = idx_reg == limit;
  assign ebyte = (a27 & ~{9'h000, limit}) | {9'h000, idx_reg};

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    state_next     = state_reg;
    op_next        = op_reg;
    wide_next      = wide_reg;
    cnt_next       = cnt_reg;
    addr_next      = addr_reg;
    ptr_next       = ptr_reg;
    idx_next       = idx_reg;
    wel_next       = wel_reg;
    perr_next      = perr_reg;
    eerr_next      = eerr_reg;
    arr_addr_next  = arr_addr_o;
    arr_rd_next    = 1'b0;
    arr_wr_next    = 1'b0;
    arr_wdata_next = arr_wdata_o;
    buf_clr        = 1'b0;
    buf_wr         = 1'b0;
    buf_wr_idx     = ptr_reg;
    case (state_reg)
      // Frames seen while busy are ignored; wait for a fresh select.
      ST_IDLE: begin
        if (cs_fall) begin
          state_next = ST_FRAME;
          cnt_next   = 3'd0;
          op_next    = OP_NONE;
          buf_clr    = 1'b1;
        end
      end
      ST_FRAME: begin
        if (byte_stb) begin
          if (cnt_reg == 3'd0) begin
            op_next   = decode_op(link_byte);
            wide_next = wide_op(link_byte) | address_length_bit_i;
            addr_next = 32'h0;
          end else if (cnt_reg <= nb) begin
            addr_next = {addr_reg[23:0], link_byte};
          end else if (op_reg == OP_PROG) begin
            // First data byte starts at the supplied offset.
            if (cnt_reg == nb + 3'd1) begin
              buf_wr_idx = addr_reg[8:0] & pmask;
            end
            buf_wr   = 1'b1;
            // Wrap to byte zero of the same page.
            ptr_next = (buf_wr_idx & ~pmask) | ((buf_wr_idx + 9'd1) & pmask);
          end
          if (cnt_reg != `FPE_CNT_SAT) begin
            cnt_next = cnt_reg + 3'd1;
          end
        end else if (cs_rise) begin
          state_next = ST_IDLE;
          case (op_reg)
            OP_WEN: begin
              if (cnt_reg == 3'd1) begin
                wel_next = 1'b1;
              end
            end
            OP_WDI: begin
              if (cnt_reg == 3'd1) begin
                wel_next = 1'b0;
              end
            end
            OP_CLR: begin
              if (cnt_reg == 3'd1) begin
                perr_next = 1'b0;
                eerr_next = 1'b0;
              end
            end
            // At least one data byte after the address.
            OP_PROG: begin
              if (wel_reg && cnt_reg >= nb + 3'd2) begin
                state_next = ST_CHECK;
              end
            end
            // Select must rise right after the address.
            OP_PERASE: begin
              if (wel_reg && cnt_reg == nb + 3'd1 && !sector_layout_bit_i &&
                  in_param(a27, param_top_i)) begin
                state_next = ST_CHECK;
              end
            end
            OP_SERASE: begin
              if (wel_reg && cnt_reg == nb + 3'd1) begin
                state_next = ST_CHECK;
              end
            end
            default: begin
              state_next = ST_IDLE;
            end
          endcase
        end
      end
      // Protection answer for the queried address.
      ST_CHECK: begin
        idx_next = 18'h0;
        if (protect_hit_i) begin
          state_next = ST_DONE;
          if (op_reg == OP_PROG) begin
            perr_next = 1'b1;
          end else begin
            eerr_next = 1'b1;
          end
        end else if (op_reg == OP_PROG) begin
          state_next = ST_PRD;
        end else begin
          state_next = ST_ERASE;
        end
      end
      // Only loaded bytes reach the array.
      ST_PRD: begin
        if (buf_valid) begin
          arr_addr_next = (a27 & ~{18'h0, pmask}) | {18'h0, idx_reg[8:0]};
          arr_rd_next   = 1'b1;
          state_next    = ST_PWAIT;
        end else if (last) begin
          state_next = ST_DONE;
        end else begin
          idx_next = idx_reg + 18'd1;
        end
      end
      ST_PWAIT: begin
        state_next = ST_PWR;
      end
      // Old data ANDed in, so a 0 can never return to 1.
      ST_PWR: begin
        arr_wr_next    = 1'b1;
        arr_wdata_next = arr_rdata_i & buf_rdata;
        idx_next       = idx_reg + 18'd1;
        state_next     = last ? ST_DONE : ST_PRD;
      end
      // One byte of FFh per cycle; pre-programming is folded away.
      ST_ERASE: begin
        arr_addr_next  = ebyte;
        arr_wdata_next = `FPE_ERASED_BYTE;
        // Overlaid parameter sectors survive a sector erase.
        arr_wr_next    = !(op_reg == OP_SERASE && !sector_layout_bit_i &&
                           in_param(ebyte, param_top_i));
        idx_next       = idx_reg + 18'd1;
        if (last) begin
          state_next = ST_DONE;
        end
      end
      ST_DONE: begin
        wel_next   = 1'b0;
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    // Busy covers check, array work and the closing cycle.
    status_next = 8'h00;
    status_next[`FPE_SR1_WIP]  = state_next inside {ST_CHECK, ST_PRD, ST_PWAIT,
                                                  ST_PWR, ST_ERASE, ST_DONE};
    status_next[`FPE_SR1_WEL]  = wel_next;
    status_next[`FPE_SR1_EERR] = eerr_next;
    status_next[`FPE_SR1_PERR] = perr_next;
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_reg        <= ST_IDLE;
      op_reg           <= OP_NONE;
      wide_reg         <= 1'b0;
      cnt_reg          <= 3'd0;
      addr_reg         <= 32'h0;
      ptr_reg          <= 9'h000;
      idx_reg          <= 18'h0;
      wel_reg          <= 1'b0;
      perr_reg         <= 1'b0;
      eerr_reg         <= 1'b0;
      arr_addr_o       <= 27'h0;
      arr_rd_o         <= 1'b0;
      arr_wr_o         <= 1'b0;
      arr_wdata_o      <= 8'h00;
      prot_addr_o      <= 27'h0;
      status_reg_one_o <= 8'h00;
    end else begin
      state_reg        <= state_next;
      op_reg           <= op_next;
      wide_reg         <= wide_next;
      cnt_reg          <= cnt_next;
      addr_reg         <= addr_next;
      ptr_reg          <= ptr_next;
      idx_reg          <= idx_next;
      wel_reg          <= wel_next;
      perr_reg         <= perr_next;
      eerr_reg         <= eerr_next;
      arr_addr_o       <= arr_addr_next;
      arr_rd_o         <= arr_rd_next;
      arr_wr_o         <= arr_wr_next;
      arr_wdata_o      <= arr_wdata_next;
      prot_addr_o      <= addr_next[26:0];
      status_reg_one_o <= status_next;
    end
  end
endmodule : fpe_sequencer

// ==== test/fpe_seq_sva.sv ====
// Port assertions for the program/erase sequencer.
`timescale 1ns/1ps
module fpe_seq_sva (
  input wire logic        clk_i,
  input wire logic        reset_i,
  input wire logic        sck_i,
  input wire logic        cs_n_i,
  input wire logic [3:0]  io_i,
  input wire logic        quad_all_mode_i,
  input wire logic        address_length_bit_i,
  input wire logic        page_size_bit_i,
  input wire logic        sector_layout_bit_i,
  input wire logic        param_top_i,
  input wire logic        protect_hit_i,
  input wire logic [7:0]  arr_rdata_i,
  input wire logic [26:0] prot_addr_o,
  input wire logic [26:0] arr_addr_o,
  input wire logic        arr_rd_o,
  input wire logic        arr_wr_o,
  input wire logic [7:0]  arr_wdata_o,
  input wire logic [7:0]  status_reg_one_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  wire write_in_progress = status_reg_one_o[0];  // Progress flag.
  wire write_enable_latch = status_reg_one_o[1];  // Write enable latch.
  wr_when_busy_a: assert property (arr_wr_o |-> write_in_progress) else $error("array write while idle");
  rd_when_busy_a: assert property (arr_rd_o |-> write_in_progress) else $error("array read while idle");
  clear_only_a: assert property (arr_wr_o && $past(arr_rd_o, 2) |->
    (arr_wdata_o & ~$past(arr_rdata_i)) == 8'h00) else $error("program sets a bit");
  erase_fill_a: assert property (arr_wr_o && !$past(arr_rd_o, 2) |-> arr_wdata_o == 8'hff) else $error("bad fill");
  start_latch_a: assert property ($rose(write_in_progress) |-> $past(write_enable_latch)) else $error("busy without latch");
  start_at_cs_a: assert property ($rose(write_in_progress) |-> cs_n_i && $past(cs_n_i, 4)) else $error("early start");
  done_drop_latch_a: assert property ($fell(write_in_progress) |-> !write_enable_latch) else $error("latch kept");
  prog_err_a: assert property ($rose(status_reg_one_o[6]) |-> ##[0:2] !write_enable_latch) else $error("latch kept");
  erase_err_a: assert property ($rose(status_reg_one_o[5]) |-> ##[0:2] !write_enable_latch) else $error("latch kept");
  cover property ($rose(write_in_progress));
  cover property ($rose(status_reg_one_o[5]));
  cover property ($rose(status_reg_one_o[6]));
endmodule : fpe_seq_sva
bind fpe_sequencer fpe_seq_sva i_sva (.*);

// ==== test/fpe_host_model.sv ====
// Host controller model that sends whole frames on the link pins.
`timescale 1ns/1ps
module fpe_host_model (
  input  wire logic quad_i,  // Quad-all mode, nibble per edge.
  output logic       sck_o,   // Link clock, still between frames.
  output logic       cs_n_o,  // Chip select.
  output logic [3:0] io_o     // IO lines.
);
  logic [7:0] q[$];  // Bytes of the next frame, opcode first.
  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    io_o = 4'h0;
  end
  // Bits change while the clock is low; high nibble or bit goes first.
  task automatic send();
    logic [7:0] b;
    cs_n_o = 1'b0;
    while (q.size() > 0) begin
      b = q.pop_front();
      for (int i = 7; i >= 0; i -= (quad_i ? 4 : 1)) begin
        io_o = quad_i ? b[i-:4] : {3'h0, b[i]};
        #40 sck_o = 1'b1;
        #40 sck_o = 1'b0;
      end
    end
    #20 cs_n_o = 1'b1;
    io_o = ~io_o;  // Released lines must not keep the last value.
    #80;
  endtask : send
endmodule : fpe_host_model

// ==== test/tb_spi_flash_program_erase_cmds.sv ====
// Self-checking bench for the program/erase sequencer.
`timescale 1ns/1ps
module tb_spi_flash_program_erase_cmds;
  import fpe_pkg::*;
  logic clk_i = 1'b0, reset_i = 1'b1, sck_i, cs_n_i, quad_all_mode_i = 1'b0;
  logic address_length_bit_i = 1'b0, page_size_bit_i = 1'b0, sector_layout_bit_i = 1'b0;
  logic param_top_i = 1'b0, protect_hit_i = 1'b0, arr_rd_o, arr_wr_o;
  logic [3:0] io_i;
  logic [7:0] arr_rdata_i = 8'h00, arr_wdata_o, status_reg_one_o, d[3];
  logic [26:0] prot_addr_o, arr_addr_o;
  logic [7:0] mem [int];  // Array model; absent bytes read erased.
  int mismatches = 0, check_count = 0, wr_count = 0, seed;
  fpe_sequencer i_dut (.*);
  fpe_host_model i_host (.quad_i(quad_all_mode_i), .sck_o(sck_i), .cs_n_o(cs_n_i), .io_o(io_i));
  initial forever #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    arr_rdata_i <= (arr_rd_o && mem.exists(arr_addr_o)) ? mem[arr_addr_o] : 8'hff;
    if (arr_wr_o) begin
      mem[arr_addr_o] = arr_wdata_o;
      wr_count++;
    end
  end
  function automatic logic [7:0] pgm(input logic [7:0] old, input logic [7:0] nw);
    return old & nw;  // Programming can only clear bits.
  endfunction : pgm
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask : chk
  // Send the queued frame, wait out any operation, then judge it.
  task automatic go(input int ew, input logic [7:0] es);
    int w0, n;
    w0 = wr_count;
    n = 0;
    i_host.send();
    repeat (12) @(negedge clk_i);
    while (status_reg_one_o[0] !== 1'b0 && n < 5000) begin
      @(negedge clk_i);
      n++;
    end
    chk("writes", wr_count - w0, ew);
    chk("status", status_reg_one_o, es);
  endtask : go
  task automatic write_enable_cmd(input logic [7:0] es);
    i_host.q = '{8'h06};
    go(0, es);
  endtask : write_enable_cmd
  task automatic final_report();
    if (mismatches == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : final_report
  initial begin
    #900_000;
    mismatches++;
    final_report();
  end
  initial begin
    seed = 32'h3bce;
    for (int k = 0; k < 3; k++) d[k] = 8'($random(seed));
    mem[27'h1fe] = 8'h3c;
    mem[27'h2abc] = 8'h00;
    repeat (16) @(negedge clk_i);
    reset_i = 1'b0;
    repeat (4) @(negedge clk_i);
    i_host.q = '{8'h02, 8'h00, 8'h01, 8'hfe, d[0]};
    go(0, 8'h00);
    write_enable_cmd(8'h02);
    i_host.q = '{8'h02, 8'h00, 8'h01, 8'hfe, d[0], d[1], d[2]};
    go(3, 8'h00);
    chk("byte 1fe", mem[27'h1fe], pgm(8'h3c, d[0]));
    chk("byte 1ff", mem[27'h1ff], pgm(8'hff, d[1]));
    chk("byte 100", mem[27'h100], pgm(8'hff, d[2]));
    chk("byte 200", mem.exists(27'h200), 0);
    quad_all_mode_i = 1'b1;
    protect_hit_i = 1'b1;
    write_enable_cmd(8'h02);
    i_host.q = '{8'h12, 8'h00, 8'h00, 8'h01, 8'h00, d[0]};
    go(0, 8'h40);
    chk("prot addr", prot_addr_o, 27'h100);
    write_enable_cmd(8'h42);
    i_host.q = '{8'h21, 8'h00, 8'h00, 8'h20, 8'h00};
    go(0, 8'h60);
    i_host.q = '{8'h30};
    go(0, 8'h00);
    protect_hit_i = 1'b0;
    write_enable_cmd(8'h02);
    i_host.q = '{8'h21, 8'h00, 8'h00, 8'h20, 8'h00, 8'h00};
    go(0, 8'h02);
    i_host.q = '{8'h21, 8'h00, 8'h01, 8'h00, 8'h00};
    go(0, 8'h02);
    sector_layout_bit_i = 1'b1;
    i_host.q = '{8'h21, 8'h00, 8'h00, 8'h20, 8'h00};
    go(0, 8'h02);
    sector_layout_bit_i = 1'b0;
    i_host.q = '{8'h60};
    go(0, 8'h02);
    i_host.q = '{8'hc7};
    go(0, 8'h02);
    address_length_bit_i = 1'b1;
    i_host.q = '{8'h20, 8'h00, 8'h00, {4'h2, d[1][3:0]}, d[2]};
    go(4096, 8'h00);
    chk("erased byte", mem[27'h2abc], 8'hff);
    chk("next sector", mem.exists(27'h3000), 0);
    page_size_bit_i = 1'b1;
    write_enable_cmd(8'h02);
    i_host.q = '{8'h02, 8'h00, 8'h00, 8'h04, 8'hfe, d[0], d[1], d[2]};
    go(3, 8'h00);
    chk("byte 500", mem[27'h500], pgm(8'hff, d[2]));
    protect_hit_i = 1'b1;
    write_enable_cmd(8'h02);
    i_host.q = '{8'hdc, 8'h04, 8'h00, 8'h00, 8'h00};
    go(0, 8'h20);
    chk("prot addr", prot_addr_o, 27'h4000000);
    final_report();
  end
endmodule : tb_spi_flash_program_erase_cmds
